// file: logic/touch_if_defines.svh
`ifndef TOUCH_IF_DEFINES_SVH
`define TOUCH_IF_DEFINES_SVH
// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define ADDR_SOFT_RESET 16'h0000
`define ADDR_EVT_CFG 16'h0008
`define ADDR_TOUCH_CFG 16'h0040
`define ADDR_TOUCH_LO 16'h0045
`define ADDR_TOUCH_HI 16'h0046
// --------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------
`define EVT_POL_BIT 15
`define READY_BIT 3
`define EVT_CFG_RST 16'h0000
`define TOUCH_CFG_RST 16'h8030
// --------------------------------------------------------------
// link constants
// --------------------------------------------------------------
`define I2C_BASE_ADDR 7'h2c
// identification value is arbitrary
`define SPI_IDENT 4'h5
`define SPI_HDR_LAST 6'h07
`define SPI_ADDR_LAST 6'h17
`define SPI_DATA_FIRST 6'h20
`define SPI_DATA_END 6'h30
`define SPI_DATA_LAST 6'h2f
// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define MCLK_PERIOD_NS 4
`define INIT_TIME_NS 1000
`define INIT_CYCLES ((`INIT_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

// file: logic/touch_if_pkg.sv
`default_nettype none
package touch_if_pkg;
    // strap encoding of the host link
    typedef enum logic [1:0] {
        LINK_I2C = 2'b00,
        LINK_SMBUS = 2'b01,
        LINK_SPI = 2'b10,
        LINK_NONE = 2'b11
    } link_mode_type;
    // i2c byte engine states, one-hot
    typedef enum logic [4:0] {
        I_IDLE = 5'b00001,
        I_RX = 5'b00010,
        I_ACK = 5'b00100,
        I_TX = 5'b01000,
        I_MACK = 5'b10000
    } i2c_state_type;
endpackage
`default_nettype wire

// file: logic/touch_sensor_host_interface.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_if_defines.svh"
module touch_sensor_host_interface
    import touch_if_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [1:0] i_if_sel,
    input wire logic i_addr_strap_0,
    input wire logic i_addr_strap_1,
    input wire logic i_touch_event,
    input wire logic [15:0] i_touch_state_lo,
    input wire logic [15:0] i_touch_state_hi,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_csn,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe_n,
    output logic o_event_pin,
    output logic o_ready,
    output logic [15:0] o_touch_cfg
);
    link_mode_type mode_q;
    logic [6:0] dev_addr_q;
    logic i2c_on, spi_on;
    logic soft_q, reg_rst;
    logic [15:0] evt_cfg_q, touch_cfg_q, rd_data, rd_hold_q;
    logic evt_q, evt_clr;
    logic [7:0] init_cnt_q;
    logic ready_q;
    logic acc_req, acc_wr;
    logic [15:0] acc_addr, acc_wdata;
    // i2c side
    logic [2:0] scl_s_q, sda_s_q;
    logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
    logic scl_rise, scl_fall, i2c_start, i2c_stop;
    i2c_state_type state_q;
    logic [3:0] bit_cnt_q;
    logic [2:0] byte_idx_q;
    logic [7:0] sh_q;
    logic rd_dir_q, tx_lo_q, mack_q;
    logic [15:0] reg_addr_q, i2c_wdata_q;
    logic i2c_req_q, i2c_wr_q;
    // spi side, link clock
    logic [5:0] spi_cnt_q;
    logic [15:0] spi_sh_q, spi_addr_q, spi_wdata_q, spi_out_q;
    logic [7:0] spi_hdr_q;
    logic spi_tgl_q, spi_wr_q;
    logic [2:0] spi_s_q;
    logic spi_seen_q, spi_evt, spi_ident_ok;

    // --------------------------------------------------------------
    // straps and link selection
    // --------------------------------------------------------------
    // straps caught while reset is held
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            mode_q <= link_mode_type'(i_if_sel);
            dev_addr_q <= `I2C_BASE_ADDR + {5'h00, i_addr_strap_1, i_addr_strap_0};
        end
    end
    assign i2c_on = (mode_q == LINK_I2C) || (mode_q == LINK_SMBUS);
    assign spi_on = (mode_q == LINK_SPI);

    // --------------------------------------------------------------
    // register access and defaults
    // --------------------------------------------------------------
    // one request source at a time, chosen by the strap mode
    assign acc_req = i2c_req_q || spi_evt;
    assign acc_wr = i2c_req_q ? i2c_wr_q : spi_wr_q;
    assign acc_addr = i2c_req_q ? reg_addr_q : spi_addr_q;
    assign acc_wdata = i2c_req_q ? i2c_wdata_q : spi_wdata_q;
    assign reg_rst = !i_nrst || soft_q;

    // write to offset zero restores defaults two cycles later
    always_ff @(posedge i_mclk)
    begin
        soft_q <= i_nrst && acc_req && acc_wr && (acc_addr == `ADDR_SOFT_RESET);
    end

    // writable registers
    always_ff @(posedge i_mclk)
    begin
        if (reg_rst)
        begin
            evt_cfg_q <= `EVT_CFG_RST;
            touch_cfg_q <= `TOUCH_CFG_RST;
        end
        else if (acc_req && acc_wr)
        begin
            if (acc_addr == `ADDR_EVT_CFG)
                evt_cfg_q <= acc_wdata;
            if (acc_addr == `ADDR_TOUCH_CFG)
                touch_cfg_q <= acc_wdata;
        end
    end

    // read mux, unmapped reads return zero
    always_comb
    begin
        rd_data = 16'h0000;
        unique case (acc_addr)
            `ADDR_EVT_CFG: rd_data = evt_cfg_q;
            `ADDR_TOUCH_CFG: rd_data = {touch_cfg_q[15:4], ready_q, touch_cfg_q[2:0]};
            `ADDR_TOUCH_LO: rd_data = i_touch_state_lo;
            `ADDR_TOUCH_HI: rd_data = i_touch_state_hi;
            default: rd_data = 16'h0000;
        endcase
    end

    // read data held for the serial engines
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
            rd_hold_q <= 16'h0000;
        else if (acc_req && !acc_wr)
            rd_hold_q <= rd_data;
    end

    // self-initialisation window after either reset
    always_ff @(posedge i_mclk)
    begin
        if (reg_rst)
        begin
            init_cnt_q <= 8'(`INIT_CYCLES);
            ready_q <= 1'b0;
        end
        else if (init_cnt_q != 8'h00)
        begin
            init_cnt_q <= init_cnt_q - 8'h01;
            ready_q <= (init_cnt_q == 8'h01);
        end
    end
    assign o_ready = ready_q;
    assign o_touch_cfg = touch_cfg_q;

    // --------------------------------------------------------------
    // event pin
    // --------------------------------------------------------------
    assign evt_clr = acc_req && !acc_wr &&
        ((acc_addr == `ADDR_TOUCH_LO) || (acc_addr == `ADDR_TOUCH_HI));

    // new event wins over a clearing read
    always_ff @(posedge i_mclk)
    begin
        if (reg_rst)
            evt_q <= 1'b0;
        else if (i_touch_event)
            evt_q <= 1'b1;
        else if (evt_clr)
            evt_q <= 1'b0;
    end
    assign o_event_pin = evt_cfg_q[`EVT_POL_BIT] ? evt_q : !evt_q;

    // --------------------------------------------------------------
    // i2c pin sampling
    // --------------------------------------------------------------
    // three stages, level accepted when last two agree
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_s_q <= {scl_s_q[1:0], i_scl};
            sda_s_q <= {sda_s_q[1:0], i_sda};
            if (scl_s_q[1] == scl_s_q[2])
                scl_f_q <= scl_s_q[2];
            if (sda_s_q[1] == sda_s_q[2])
                sda_f_q <= sda_s_q[2];
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
        end
    end
    assign scl_rise = scl_f_q && !scl_p_q;
    assign scl_fall = !scl_f_q && scl_p_q;
    assign i2c_start = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
    assign i2c_stop = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;

    // --------------------------------------------------------------
    // i2c byte engine
    // --------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            state_q <= I_IDLE;
            bit_cnt_q <= 4'h0;
            byte_idx_q <= 3'h0;
            sh_q <= 8'h00;
            rd_dir_q <= 1'b0;
            tx_lo_q <= 1'b0;
            mack_q <= 1'b0;
            reg_addr_q <= 16'h0000;
            i2c_wdata_q <= 16'h0000;
            i2c_req_q <= 1'b0;
            i2c_wr_q <= 1'b0;
        end
        else
        begin
            i2c_req_q <= 1'b0;
            if (!i2c_on)
                state_q <= I_IDLE;
            else if (i2c_start)
            begin
                state_q <= I_RX; // repeated start keeps the register address
                bit_cnt_q <= 4'h0;
                byte_idx_q <= 3'h0;
            end
            else if (i2c_stop)
                state_q <= I_IDLE;
            else
                unique case (state_q)
                    I_IDLE: state_q <= I_IDLE;
                    I_RX:
                    begin
                        if (scl_rise)
                        begin
                            sh_q <= {sh_q[6:0], sda_f_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        else if (scl_fall && (bit_cnt_q == 4'h8))
                        begin
                            bit_cnt_q <= 4'h0;
                            state_q <= I_ACK;
                            byte_idx_q <= (byte_idx_q == 3'h4) ? 3'h4 : byte_idx_q + 3'h1;
                            unique case (byte_idx_q)
                                3'h0:
                                begin
                                    if (sh_q[7:1] != dev_addr_q)
                                        state_q <= I_IDLE;
                                    rd_dir_q <= sh_q[0];
                                    tx_lo_q <= 1'b0;
                                    if (sh_q[7:1] == dev_addr_q && sh_q[0])
                                    begin
                                        i2c_req_q <= 1'b1;
                                        i2c_wr_q <= 1'b0;
                                    end
                                end
                                3'h1: reg_addr_q[15:8] <= sh_q;
                                3'h2: reg_addr_q[7:0] <= sh_q;
                                3'h3: i2c_wdata_q[15:8] <= sh_q;
                                default:
                                begin
                                    i2c_wdata_q[7:0] <= sh_q;
                                    i2c_req_q <= 1'b1;
                                    i2c_wr_q <= 1'b1;
                                end
                            endcase
                        end
                    end
                    I_ACK:
                    begin
                        if (scl_fall)
                        begin
                            state_q <= rd_dir_q ? I_TX : I_RX;
                            sh_q <= rd_hold_q[15:8];
                        end
                    end
                    I_TX:
                    begin
                        if (scl_fall && (bit_cnt_q == 4'h7))
                        begin
                            state_q <= I_MACK;
                            bit_cnt_q <= 4'h0;
                        end
                        else if (scl_fall)
                        begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                    I_MACK:
                    begin
                        if (scl_rise)
                            mack_q <= !sda_f_q;
                        else if (scl_fall)
                        begin
                            state_q <= mack_q ? I_TX : I_IDLE;
                            tx_lo_q <= !tx_lo_q;
                            sh_q <= tx_lo_q ? rd_hold_q[15:8] : rd_hold_q[7:0];
                        end
                    end
                endcase
        end
    end
    // open-drain: only ever pulls low
    assign o_sda_out = 1'b0;
    assign o_sda_oe_n = !((state_q == I_ACK) || ((state_q == I_TX) && !sh_q[7]));

    // --------------------------------------------------------------
    // spi link, on the host's serial clock
    // --------------------------------------------------------------
    // bit counter cleared while select is high
    always_ff @(posedge i_spi_sclk or posedge i_spi_csn)
    begin
        if (i_spi_csn)
            spi_cnt_q <= 6'h00;
        else if (spi_cnt_q != 6'h3f)
            spi_cnt_q <= spi_cnt_q + 6'h01;
    end

    // input shifter, msb first
    always_ff @(posedge i_spi_sclk)
    begin
        spi_sh_q <= {spi_sh_q[14:0], i_spi_mosi};
    end
    assign spi_ident_ok = (spi_hdr_q[7:4] == `SPI_IDENT);

    // header, address, parameter and request toggle
    always_ff @(posedge i_spi_sclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            spi_hdr_q <= 8'h00;
            spi_addr_q <= 16'h0000;
            spi_wdata_q <= 16'h0000;
            spi_tgl_q <= 1'b0;
            spi_wr_q <= 1'b0;
        end
        else
        begin
            if (spi_cnt_q == `SPI_HDR_LAST)
                spi_hdr_q <= {spi_sh_q[6:0], i_spi_mosi};
            if (spi_cnt_q == `SPI_ADDR_LAST)
            begin
                spi_addr_q <= {spi_sh_q[14:0], i_spi_mosi};
                if (spi_ident_ok && spi_hdr_q[3])
                begin
                    spi_tgl_q <= !spi_tgl_q;
                    spi_wr_q <= 1'b0;
                end
            end
            if ((spi_cnt_q == `SPI_DATA_LAST) && spi_ident_ok && !spi_hdr_q[3])
            begin
                spi_wdata_q <= {spi_sh_q[14:0], i_spi_mosi};
                spi_tgl_q <= !spi_tgl_q;
                spi_wr_q <= 1'b1;
            end
        end
    end

    // read word loaded after the turnaround byte
    always_ff @(negedge i_spi_sclk or negedge i_nrst)
    begin
        if (!i_nrst)
            spi_out_q <= 16'h0000;
        else if (spi_cnt_q == `SPI_DATA_FIRST)
            spi_out_q <= rd_hold_q;
        else
            spi_out_q <= {spi_out_q[14:0], 1'b0};
    end
    assign o_spi_miso = spi_out_q[15];
    assign o_spi_miso_oe_n = !(spi_on && !i_spi_csn && spi_ident_ok && spi_hdr_q[3] &&
        (spi_cnt_q >= `SPI_DATA_FIRST) && (spi_cnt_q < `SPI_DATA_END));

    // request toggle into the system clock
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            spi_s_q <= 3'h0;
            spi_seen_q <= 1'b0;
        end
        else
        begin
            spi_s_q <= {spi_s_q[1:0], spi_tgl_q};
            if (spi_s_q[1] == spi_s_q[2])
                spi_seen_q <= spi_s_q[2];
        end
    end
    assign spi_evt = spi_on && (spi_s_q[1] == spi_s_q[2]) && (spi_s_q[2] != spi_seen_q);

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    sequence evt_taken_s;
        i_touch_event && !soft_q;
    endsequence
    sequence status_read_s;
        evt_clr && !i_touch_event && !soft_q;
    endsequence

    link_select_a: assert property (acc_req |-> (mode_q != LINK_NONE)
        && (i2c_req_q == i2c_on))
        else $error("register request from a link not selected");
    event_polarity_a: assert property (evt_taken_s |=> o_event_pin == evt_cfg_q[15])
        else $error("event pin not at active level");
    event_set_wins_a: assert property (i_touch_event && evt_clr && !soft_q |=> evt_q)
        else $error("event lost against clear");
    status_clear_a: assert property (status_read_s |=> o_event_pin != evt_cfg_q[15])
        else $error("status read left pin active");
    soft_reset_a: assert property (acc_req && acc_wr && acc_addr == 16'h0000
        |=> ##1 !ready_q && evt_cfg_q == 16'h0000 && !evt_q)
        else $error("soft reset did not restore defaults");
    ready_timing_a: assert property ($rose(ready_q) |-> $past(init_cnt_q) == 8'h01)
        else $error("ready rose early");
    i2c_addr_a: assert property (state_q == I_RX && scl_fall && bit_cnt_q == 4'h8
        && byte_idx_q == 3'h0 && sh_q[7:1] != dev_addr_q && !i2c_start && !i2c_stop
        |=> state_q == I_IDLE && !i2c_req_q)
        else $error("foreign i2c address acknowledged");
    sda_drive_a: assert property (!o_sda_oe_n |-> i2c_on
        && state_q inside {I_ACK, I_TX})
        else $error("sda driven outside ack or data");
    spi_ident_a: assert property (spi_evt |-> spi_hdr_q[7:4] == 4'h5)
        else $error("spi request with wrong ident");
endmodule
`default_nettype wire

// file: tb/host_link_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_if_defines.svh"
// -----------------------------------------
// host side serial master, spi and i2c
// -----------------------------------------
module host_link_model (
    input wire logic i_miso,
    input wire logic i_miso_oe_n,
    input wire logic i_sda,
    output logic o_sclk,
    output logic o_csn,
    output logic o_mosi,
    output logic o_scl,
    output logic o_sda_low
);
    localparam int H = 60;
    // idle levels, link clock stands still
    initial
    begin
        o_sclk = 1'b0;
        o_csn = 1'b1;
        o_mosi = 1'b0;
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // four-wire frame, mode 0, 6 ns clock
    task automatic spi(input logic [3:0] id, input logic rw, input logic [15:0] adr,
        input logic [15:0] wd, output logic [15:0] rd, output logic drv);
        logic [47:0] f;
        f = {id, rw, 3'b000, adr, 8'h00, wd};
        rd = 16'h0000;
        drv = 1'b0;
        o_csn = 1'b0;
        for (int i = 47; i >= 0; i--)
        begin
            o_mosi = f[i];
            #3 o_sclk = 1'b1;
            if (i < 16)
            begin
                // a released line reads back inverted
                rd = {rd[14:0], i_miso_oe_n ? !i_miso : i_miso};
                drv = drv | !i_miso_oe_n;
            end
            #3 o_sclk = 1'b0;
        end
        #3 o_csn = 1'b1;
        o_mosi = !o_mosi; // deselected line shows no stale bit
        #40;
    endtask
    // start or repeated start (0), stop (1)
    task automatic edge_cond(input logic stop);
        #(H/2) o_sda_low = stop;
        #(H/2) o_scl = 1'b1;
        #H o_sda_low = !stop;
        #H if (!stop) o_scl = 1'b0;
    endtask
    // one scl period, data moves mid-low
    task automatic bit_io(input logic b, output logic r);
        #(H/2) o_sda_low = !b;
        #(H/2) o_scl = 1'b1;
        #H r = i_sda;
        o_scl = 1'b0;
    endtask
    // eight bits msb first, then the ack slot
    task automatic byte_io(input logic [8:0] t, output logic [8:0] r);
        logic x;
        for (int i = 8; i >= 0; i--)
        begin
            bit_io(t[i], x);
            r[i] = x;
        end
    endtask
    // register write, or read through restart
    task automatic i2c(input logic [6:0] dev, input logic rw, input logic [15:0] adr,
        input logic [15:0] wd, output logic [15:0] rd, output logic ack);
        logic [8:0] r0, r1, r2, r3, r4;
        rd = 16'h0000;
        edge_cond(1'b0);
        byte_io({dev, 1'b0, 1'b1}, r0);
        byte_io({adr[15:8], 1'b1}, r1);
        byte_io({adr[7:0], 1'b1}, r2);
        ack = !r0[0] & !r1[0] & !r2[0];
        if (rw)
        begin
            edge_cond(1'b0);
            byte_io({dev, 1'b1, 1'b1}, r3);
            ack = ack & !r3[0];
            byte_io({8'hff, 1'b0}, r3);
            byte_io({8'hff, 1'b1}, r4);
            rd = {r3[8:1], r4[8:1]};
        end
        else
        begin
            byte_io({wd[15:8], 1'b1}, r3);
            byte_io({wd[7:0], 1'b1}, r4);
            ack = ack & !r3[0] & !r4[0];
        end
        edge_cond(1'b1);
    endtask
endmodule
`default_nettype wire

// file: tb/touch_sensor_host_interface_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_if_defines.svh"
module touch_sensor_host_interface_bench;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] if_sel = 2'b00;
    logic [1:0] strap = 2'b00;
    logic tev = 1'b0;
    logic [15:0] lo = 16'h0000;
    logic [15:0] hi = 16'h0000;
    logic sclk, csn, mosi, miso, miso_oe_n, scl, sda_low, sda_line;
    logic sda_out, sda_oe_n, evt, ready, a;
    logic [15:0] tcfg, r, v, seen;
    logic [6:0] dev;
    logic [2:0] m;
    logic [31:0] s = 32'h07a4;
    logic [15:0] q[$];
    int n_fail = 0;
    int comparisons = 0;
    event seen_ev;
    // -----------------------------------------
    // clock, wire level, instances
    // -----------------------------------------
    always #2 mclk = ~mclk;
    assign sda_line = (sda_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1; // pull-up
    touch_sensor_host_interface i_dut (
        .i_mclk(mclk), .i_nrst(nrst), .i_if_sel(if_sel),
        .i_addr_strap_0(strap[0]), .i_addr_strap_1(strap[1]),
        .i_touch_event(tev), .i_touch_state_lo(lo), .i_touch_state_hi(hi),
        .i_scl(scl), .i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
        .i_spi_sclk(sclk), .i_spi_csn(csn), .i_spi_mosi(mosi), .o_spi_miso(miso),
        .o_spi_miso_oe_n(miso_oe_n), .o_event_pin(evt), .o_ready(ready),
        .o_touch_cfg(tcfg)
    );
    host_link_model h (
        .i_miso(miso), .i_miso_oe_n(miso_oe_n), .i_sda(sda_line), .o_sclk(sclk),
        .o_csn(csn), .o_mosi(mosi), .o_scl(scl), .o_sda_low(sda_low)
    );
    // -----------------------------------------
    // helpers
    // -----------------------------------------
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic end_sim();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] got_v, input logic [15:0] exp_v);
        comparisons++;
        if (got_v !== exp_v)
        begin
            n_fail++;
            $display("ERROR %0t: saw %h, wanted %h", $time, got_v, exp_v);
        end
    endtask
    task automatic exp(input logic [15:0] e);
        q.push_back(e);
    endtask
    task automatic got(input logic [15:0] g);
        seen = g;
        ->seen_ev;
        #1;
    endtask
    // watcher: each result against the oldest note
    always @(seen_ev)
        check(seen, q.pop_front());
    task automatic pinchk(input logic e);
        repeat (4) @(posedge mclk);
        #1 exp({15'h0000, e});
        got({15'h0000, evt});
    endtask
    task automatic pulse();
        @(posedge mclk) #1 tev = 1'b1;
        @(posedge mclk) #1 tev = 1'b0;
    endtask
    task automatic rd(input logic sp, input logic [15:0] adr, input logic [15:0] e);
        exp(e);
        if (sp)
            h.spi(`SPI_IDENT, 1'b1, adr, 16'h0000, r, a);
        else
            h.i2c(dev, 1'b1, adr, 16'h0000, r, a);
        got(r);
    endtask
    task automatic wr(input logic sp, input logic [15:0] adr, input logic [15:0] d);
        if (sp)
            h.spi(`SPI_IDENT, 1'b0, adr, d, r, a);
        else
            h.i2c(dev, 1'b0, adr, d, r, a);
    endtask
    // long pin reset, defaults, then ready timing
    task automatic rst(input logic [1:0] md);
        @(posedge mclk) #1 nrst = 1'b0;
        if_sel = md;
        repeat (2500) @(posedge mclk);
        #1 nrst = 1'b1;
        exp(16'h8030);
        got(tcfg);
        exp(16'h0001);
        got({14'h0000, ready, evt});
        repeat (`INIT_CYCLES - 1) @(posedge mclk);
        #1 exp(16'h0000);
        got({15'h0000, ready});
        @(posedge mclk) #1 exp(16'h0001);
        got({15'h0000, ready});
    endtask
    // -----------------------------------------
    // main sequence
    // -----------------------------------------
    initial
    begin
        v = 16'(rnd());
        strap = v[1:0];
        dev = `I2C_BASE_ADDR + {5'h00, strap};
        lo = 16'(rnd());
        hi = 16'(rnd());
        for (m = 3'd0; m < 3'd4; m++)
        begin
            rst(m[1:0]);
            h.i2c(dev, 1'b0, `ADDR_EVT_CFG, 16'h8000, r, a);
            exp({15'h0000, m < 3'd2});
            got({15'h0000, a});
            pinchk(m > 3'd1);
            wr(1'b1, `ADDR_EVT_CFG, 16'h8000);
            pinchk(m == 3'd3);
        end
        rst(2'b00);
        exp(16'h0000);
        h.i2c(dev ^ 7'h01, 1'b0, `ADDR_EVT_CFG, 16'h8000, r, a);
        got({15'h0000, a});
        pinchk(1'b1);
        pulse();
        pinchk(1'b0);
        rd(1'b0, `ADDR_TOUCH_LO, lo);
        pinchk(1'b1);
        rd(1'b0, `ADDR_TOUCH_HI, hi);
        rd(1'b0, `ADDR_TOUCH_CFG, 16'h8038);
        rst(2'b10);
        wr(1'b1, `ADDR_EVT_CFG, 16'h8000);
        pinchk(1'b0);
        pulse();
        pulse();
        pinchk(1'b1);
        rd(1'b1, `ADDR_TOUCH_LO, lo);
        pinchk(1'b0);
        pulse();
        pinchk(1'b1);
        rd(1'b1, `ADDR_TOUCH_HI, hi);
        pinchk(1'b0);
        rd(1'b1, `ADDR_EVT_CFG, 16'h8000);
        rd(1'b1, 16'h0123, 16'h0000);
        // event held across a clearing status read
        fork
            rd(1'b1, `ADDR_TOUCH_LO, lo);
            begin
                #130 @(posedge mclk) #1 tev = 1'b1;
                repeat (12) @(posedge mclk);
                #1 tev = 1'b0;
            end
        join
        pinchk(1'b1);
        exp(16'h0000);
        h.spi(~`SPI_IDENT, 1'b1, `ADDR_EVT_CFG, 16'h0000, r, a);
        got({15'h0000, a});
        v = 16'(rnd());
        wr(1'b1, `ADDR_TOUCH_CFG, v);
        rd(1'b1, `ADDR_TOUCH_CFG, (v & 16'hfff7) | 16'h0008);
        wr(1'b1, `ADDR_SOFT_RESET, 16'(rnd()));
        pinchk(1'b1);
        exp(16'h8030);
        got(tcfg);
        rd(1'b1, `ADDR_EVT_CFG, 16'h0000);
        end_sim();
    end
    // watchdog against a hung run
    initial
    begin
        #400000;
        n_fail++;
        end_sim();
    end
endmodule
`default_nettype wire
